// ===== rtl/duhp_cfg.svh
// Constants of the dual channel host bus port
`ifndef DUHP_CFG_SVH
`define DUHP_CFG_SVH

// Register indexes on the three select lines
`define DUHP_REG_DATA     3'h0
`define DUHP_REG_MCTL     3'h4
`define DUHP_REG_LSR      3'h5
`define DUHP_REG_SCR      3'h7

// Modem control fields
`define DUHP_MCTL_OUT2    3
`define DUHP_MCTL_IR      6
`define DUHP_MCTL_RST     8'h00

// Line status fields
`define DUHP_LSR_RX_RDY   0
`define DUHP_LSR_OVR      1
`define DUHP_LSR_TX_EMPTY 5
`define DUHP_LSR_TX_IDLE  6

// FIFO geometry
`define DUHP_AW           7
`define DUHP_PTR_W        8
`define DUHP_DEPTH        8'h80

// Serial frame
`define DUHP_LAST_BIT     4'h9
`define DUHP_CNT_W        16

// Host strobe low time in clock cycles
`define DUHP_STROBE_CYC   3'h4

`endif

// ===== rtl/duhp_pkg.sv
// Types shared by both ends of the host bus port
`include "duhp_cfg.svh"

package duhp_pkg;

    typedef struct packed {
        logic [`DUHP_DEPTH-1:0][7:0] tx_mem;
        logic [`DUHP_DEPTH-1:0][7:0] rx_mem;
        logic [`DUHP_PTR_W-1:0]      tx_wp;
        logic [`DUHP_PTR_W-1:0]      tx_rp;
        logic [`DUHP_PTR_W-1:0]      rx_wp;
        logic [`DUHP_PTR_W-1:0]      rx_rp;
        logic [7:0]                  mctl;
        logic [7:0]                  scr;
        logic                        rx_ovr;
        logic                        tx_busy;
        logic [9:0]                  tx_sh;
        logic [3:0]                  tx_bits;
        logic [`DUHP_CNT_W-1:0]      tx_cnt;
        logic                        rx_busy;
        logic [7:0]                  rx_sh;
        logic [3:0]                  rx_bits;
        logic [`DUHP_CNT_W-1:0]      rx_cnt;
        logic                        ser_out;
        logic                        irq;
        logic                        tx_rdy_n;
        logic                        rx_rdy_n;
    } duhp_chan_t;

    typedef struct packed {
        logic                  rd_prev;
        logic                  wr_prev;
        logic                  active;
        logic                  act_chan;
        logic [7:0]            data_out;
        logic                  data_oe;
        duhp_chan_t [1:0]      chan;
    } duhp_dev_t;

    typedef enum logic [1:0] {
        DUHP_H_IDLE,
        DUHP_H_SETUP,
        DUHP_H_STROBE,
        DUHP_H_HOLD
    } duhp_host_state_t;

    typedef struct packed {
        duhp_host_state_t state;
        logic [2:0]       cnt;
        logic             write;
        logic [2:0]       addr;
        logic [7:0]       data;
        logic             data_oe;
        logic             rd_n;
        logic             wr_n;
        logic             sel_a_n;
        logic             sel_b_n;
        logic             busy;
        logic             done;
        logic [7:0]       rdata;
    } duhp_host_t;

endpackage : duhp_pkg

// ===== rtl/duhp_bus_if.sv
// Parallel host bus between host end and device end
`timescale 1ns/1ps

interface duhp_bus_if;
    logic [2:0] register_select_lines;
    logic [7:0] host_data;
    logic       host_data_oe;
    logic [7:0] dev_data;
    logic       dev_data_oe;
    logic [7:0] data_bus;
    logic       read_strobe_n;
    logic       write_strobe_n;
    logic       chan_a_select_n;
    logic       chan_b_select_n;

    // Resolved bus level, pulled high when undriven
    assign data_bus = dev_data_oe  ? dev_data  :
                      host_data_oe ? host_data : 8'hff;

    modport device (
        input  register_select_lines,
        input  data_bus,
        input  read_strobe_n,
        input  write_strobe_n,
        input  chan_a_select_n,
        input  chan_b_select_n,
        output dev_data,
        output dev_data_oe
    );

    modport host (
        output register_select_lines,
        output host_data,
        output host_data_oe,
        output read_strobe_n,
        output write_strobe_n,
        output chan_a_select_n,
        output chan_b_select_n,
        input  data_bus
    );
endinterface : duhp_bus_if

// ===== rtl/duhp_host.sv
// Host end: runs one read or write cycle on the parallel bus
`timescale 1ns/1ps
`include "duhp_cfg.svh"

module duhp_host (
    input  logic        ref_clk_in,
    input  logic        rstn_in,
    input  logic        ce_in,
    duhp_bus_if.host    bus,
    input  logic        req_valid_in,
    input  logic        req_write_in,
    input  logic        req_chan_in,
    input  logic [2:0]  req_addr_in,
    input  logic [7:0]  req_data_in,
    output logic        busy_out,
    output logic        done_out,
    output logic [7:0]  rdata_out
);

    duhp_pkg::duhp_host_t st;
    duhp_pkg::duhp_host_t next_st;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        case (st.state)
            duhp_pkg::DUHP_H_IDLE: begin
                if (req_valid_in) begin
                    next_st.state   = duhp_pkg::DUHP_H_SETUP;
                    next_st.busy    = 1'b1;
                    next_st.write   = req_write_in;
                    next_st.addr    = req_addr_in;
                    next_st.data    = req_data_in;
                    next_st.data_oe = req_write_in;
                    next_st.sel_a_n = req_chan_in;
                    next_st.sel_b_n = ~req_chan_in;
                end
            end
            duhp_pkg::DUHP_H_SETUP: begin
                next_st.state = duhp_pkg::DUHP_H_STROBE;
                next_st.cnt   = `DUHP_STROBE_CYC - 3'h1;
                // Only one strobe per cycle
                next_st.rd_n  = st.write;
                next_st.wr_n  = ~st.write;
            end
            duhp_pkg::DUHP_H_STROBE: begin
                if (st.cnt == 3'h0) begin
                    next_st.state = duhp_pkg::DUHP_H_HOLD;
                    next_st.rd_n  = 1'b1;
                    next_st.wr_n  = 1'b1;
                    if (!st.write) begin
                        next_st.rdata = bus.data_bus;
                    end
                end else begin
                    next_st.cnt = st.cnt - 3'h1;
                end
            end
            duhp_pkg::DUHP_H_HOLD: begin
                next_st.state   = duhp_pkg::DUHP_H_IDLE;
                next_st.data_oe = 1'b0;
                next_st.sel_a_n = 1'b1;
                next_st.sel_b_n = 1'b1;
                next_st.busy    = 1'b0;
                next_st.done    = 1'b1;
            end
            default: next_st.state = duhp_pkg::DUHP_H_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st         <= '0;
            st.rd_n    <= 1'b1;
            st.wr_n    <= 1'b1;
            st.sel_a_n <= 1'b1;
            st.sel_b_n <= 1'b1;
        end else if (ce_in) begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign bus.register_select_lines = st.addr;
    assign bus.host_data             = st.data;
    assign bus.host_data_oe          = st.data_oe;
    assign bus.read_strobe_n         = st.rd_n;
    assign bus.write_strobe_n        = st.wr_n;
    assign bus.chan_a_select_n       = st.sel_a_n;
    assign bus.chan_b_select_n       = st.sel_b_n;
    assign busy_out                  = st.busy;
    assign done_out                  = st.done;
    assign rdata_out                 = st.rdata;

endmodule : duhp_host

// ===== rtl/duhp_device.sv
// Device end: two serial channels behind the parallel host bus
`timescale 1ns/1ps
`include "duhp_cfg.svh"

module duhp_device #(
    parameter int BAUD_DIV = 16
) (
    input  logic        ref_clk_in,
    input  logic        rstn_in,
    input  logic        ce_in,
    duhp_bus_if.device  bus,
    input  logic [1:0]  serial_in_chan_in,
    output logic [1:0]  serial_out_chan_out,
    output logic [1:0]  irq_out_chan_out,
    output logic [1:0]  irq_oe_chan_out,
    output logic [1:0]  aux_out_two_chan_n_out,
    output logic [1:0]  xmit_ready_chan_n_out,
    output logic [1:0]  recv_ready_chan_n_out
);

    localparam logic [`DUHP_CNT_W-1:0] DIV_LAST =
        `DUHP_CNT_W'(BAUD_DIV - 1);
    localparam logic [`DUHP_CNT_W-1:0] DIV_HALF =
        `DUHP_CNT_W'(BAUD_DIV / 2 - 1);
    localparam logic [`DUHP_CNT_W-1:0] DIV_Q1 =
        `DUHP_CNT_W'(BAUD_DIV / 4);
    localparam logic [`DUHP_CNT_W-1:0] DIV_Q3 =
        `DUHP_CNT_W'((3 * BAUD_DIV) / 4);

    duhp_pkg::duhp_dev_t st;
    duhp_pkg::duhp_dev_t next_st;

    logic        rd_fall;
    logic        rd_rise;
    logic        wr_fall;
    logic        wr_rise;
    logic        any_sel;
    logic        sel_chan;
    logic [1:0]  pop_rx;
    logic [1:0]  push_tx;
    logic [1:0]  clr_ovr;
    logic        line;
    logic        tx_full;
    logic        rx_full;

    ////////////////////////////////////////////////////////////////////////
    // Register read mux of one channel
    function automatic logic [7:0] rd_mux(
        input duhp_pkg::duhp_chan_t ch,
        input logic [2:0]           a
    );
        logic [7:0] v;
        v = 8'h00;
        case (a)
            `DUHP_REG_DATA: v = ch.rx_mem[ch.rx_rp[`DUHP_AW-1:0]];
            `DUHP_REG_MCTL: v = ch.mctl;
            `DUHP_REG_SCR:  v = ch.scr;
            `DUHP_REG_LSR: begin
                v[`DUHP_LSR_RX_RDY]   = ch.rx_wp != ch.rx_rp;
                v[`DUHP_LSR_OVR]      = ch.rx_ovr;
                v[`DUHP_LSR_TX_EMPTY] = ch.tx_wp == ch.tx_rp;
                v[`DUHP_LSR_TX_IDLE]  = (ch.tx_wp == ch.tx_rp) &&
                                        !ch.tx_busy;
            end
            default: v = 8'h00;
        endcase
        return v;
    endfunction : rd_mux

    ////////////////////////////////////////////////////////////////////////
    // Host bus side
    always_comb begin
        next_st  = st;
        pop_rx   = 2'b00;
        push_tx  = 2'b00;
        clr_ovr  = 2'b00;
        line     = 1'b1;
        tx_full  = 1'b0;
        rx_full  = 1'b0;
        rd_fall  = st.rd_prev && !bus.read_strobe_n;
        rd_rise  = !st.rd_prev && bus.read_strobe_n;
        wr_fall  = st.wr_prev && !bus.write_strobe_n;
        wr_rise  = !st.wr_prev && bus.write_strobe_n;
        any_sel  = !bus.chan_a_select_n || !bus.chan_b_select_n;
        sel_chan = bus.chan_a_select_n;
        next_st.rd_prev = bus.read_strobe_n;
        next_st.wr_prev = bus.write_strobe_n;

        // Start of a cycle only with a channel selected
        if ((rd_fall || wr_fall) && any_sel) begin
            next_st.active   = 1'b1;
            next_st.act_chan = sel_chan;
        end
        if (rd_fall && any_sel) begin
            next_st.data_out = rd_mux(st.chan[sel_chan],
                                      bus.register_select_lines);
            next_st.data_oe  = 1'b1;
        end
        if (rd_rise && st.active) begin
            next_st.active  = 1'b0;
            next_st.data_oe = 1'b0;
            if (bus.register_select_lines == `DUHP_REG_DATA) begin
                pop_rx[st.act_chan] = 1'b1;
            end
            if (bus.register_select_lines == `DUHP_REG_LSR) begin
                clr_ovr[st.act_chan] = 1'b1;
            end
        end
        if (wr_rise && st.active) begin
            next_st.active = 1'b0;
            case (bus.register_select_lines)
                `DUHP_REG_DATA: push_tx[st.act_chan] = 1'b1;
                `DUHP_REG_MCTL: next_st.chan[st.act_chan].mctl = bus.data_bus;
                `DUHP_REG_SCR:  next_st.chan[st.act_chan].scr = bus.data_bus;
                default: ;
            endcase
        end

        // Per channel FIFOs and serial engines
        for (int c = 0; c < 2; c++) begin
            tx_full = (st.chan[c].tx_wp - st.chan[c].tx_rp) == `DUHP_DEPTH;
            rx_full = (st.chan[c].rx_wp - st.chan[c].rx_rp) == `DUHP_DEPTH;

            // Writes to a full transmit FIFO are dropped
            if (push_tx[c] && !tx_full) begin
                next_st.chan[c].tx_mem[st.chan[c].tx_wp[`DUHP_AW-1:0]] =
                    bus.data_bus;
                next_st.chan[c].tx_wp = st.chan[c].tx_wp + 8'h01;
            end
            if (pop_rx[c] && st.chan[c].rx_wp != st.chan[c].rx_rp) begin
                next_st.chan[c].rx_rp = st.chan[c].rx_rp + 8'h01;
            end
            if (clr_ovr[c]) begin
                next_st.chan[c].rx_ovr = 1'b0;
            end

            // Transmitter: start bit, eight data bits, stop bit
            if (!st.chan[c].tx_busy) begin
                if (st.chan[c].tx_wp != st.chan[c].tx_rp) begin
                    next_st.chan[c].tx_sh = {1'b1,
                        st.chan[c].tx_mem[st.chan[c].tx_rp[`DUHP_AW-1:0]],
                        1'b0};
                    next_st.chan[c].tx_rp   = st.chan[c].tx_rp + 8'h01;
                    next_st.chan[c].tx_busy = 1'b1;
                    next_st.chan[c].tx_bits = 4'h0;
                    next_st.chan[c].tx_cnt  = '0;
                end
            end else if (st.chan[c].tx_cnt == DIV_LAST) begin
                next_st.chan[c].tx_cnt  = '0;
                next_st.chan[c].tx_sh   = {1'b1, st.chan[c].tx_sh[9:1]};
                next_st.chan[c].tx_bits = st.chan[c].tx_bits + 4'h1;
                if (st.chan[c].tx_bits == `DUHP_LAST_BIT) begin
                    next_st.chan[c].tx_busy = 1'b0;
                end
            end else begin
                next_st.chan[c].tx_cnt = st.chan[c].tx_cnt + 1'b1;
            end

            // Line level: infrared sends a pulse mid-bit for each zero
            if (st.chan[c].mctl[`DUHP_MCTL_IR]) begin
                next_st.chan[c].ser_out = st.chan[c].tx_busy &&
                    !st.chan[c].tx_sh[0] &&
                    st.chan[c].tx_cnt >= DIV_Q1 &&
                    st.chan[c].tx_cnt < DIV_Q3;
                line = !serial_in_chan_in[c];
            end else begin
                next_st.chan[c].ser_out = !st.chan[c].tx_busy ||
                                          st.chan[c].tx_sh[0];
                line = serial_in_chan_in[c];
            end

            // Receiver samples each bit at its middle
            if (!st.chan[c].rx_busy) begin
                if (!line) begin
                    next_st.chan[c].rx_busy = 1'b1;
                    next_st.chan[c].rx_bits = 4'h0;
                    // An infrared pulse begins a quarter into the bit
                    next_st.chan[c].rx_cnt  =
                        st.chan[c].mctl[`DUHP_MCTL_IR] ? DIV_Q1 : '0;
                end
            end else begin
                if (st.chan[c].rx_cnt == DIV_LAST) begin
                    next_st.chan[c].rx_cnt  = '0;
                    next_st.chan[c].rx_bits = st.chan[c].rx_bits + 4'h1;
                end else begin
                    next_st.chan[c].rx_cnt = st.chan[c].rx_cnt + 1'b1;
                end
                if (st.chan[c].rx_cnt == DIV_HALF) begin
                    if (st.chan[c].rx_bits == 4'h0) begin
                        next_st.chan[c].rx_busy = !line;
                    end else if (st.chan[c].rx_bits == `DUHP_LAST_BIT) begin
                        next_st.chan[c].rx_busy = 1'b0;
                        if (rx_full) begin
                            // Overrun set beats a same-cycle clear
                            next_st.chan[c].rx_ovr = 1'b1;
                        end else begin
                            next_st.chan[c].rx_mem[
                                st.chan[c].rx_wp[`DUHP_AW-1:0]] =
                                st.chan[c].rx_sh;
                            next_st.chan[c].rx_wp =
                                st.chan[c].rx_wp + 8'h01;
                        end
                    end else begin
                        next_st.chan[c].rx_sh = {line,
                                                 st.chan[c].rx_sh[7:1]};
                    end
                end
            end

            // Status pins from the FIFO occupancy after this cycle
            next_st.chan[c].tx_rdy_n =
                (next_st.chan[c].tx_wp - next_st.chan[c].tx_rp)
                == `DUHP_DEPTH;
            next_st.chan[c].rx_rdy_n =
                next_st.chan[c].rx_wp == next_st.chan[c].rx_rp;
            next_st.chan[c].irq = !next_st.chan[c].rx_rdy_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st         <= '0;
            st.rd_prev <= 1'b1;
            st.wr_prev <= 1'b1;
            for (int c = 0; c < 2; c++) begin
                st.chan[c].mctl     <= `DUHP_MCTL_RST;
                st.chan[c].ser_out  <= 1'b1;
                st.chan[c].rx_rdy_n <= 1'b1;
            end
        end else if (ce_in) begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign bus.dev_data    = st.data_out;
    assign bus.dev_data_oe = st.data_oe;

    for (genvar g = 0; g < 2; g++) begin : g_chan
        assign serial_out_chan_out[g]    = st.chan[g].ser_out;
        assign irq_out_chan_out[g]       = st.chan[g].irq;
        // Interrupt pin enable and aux pin follow the out-two bit
        assign irq_oe_chan_out[g]        =
            st.chan[g].mctl[`DUHP_MCTL_OUT2];
        assign aux_out_two_chan_n_out[g] =
            !st.chan[g].mctl[`DUHP_MCTL_OUT2];
        assign xmit_ready_chan_n_out[g]  = st.chan[g].tx_rdy_n;
        assign recv_ready_chan_n_out[g]  = st.chan[g].rx_rdy_n;
    end

endmodule : duhp_device

// ===== verification/duhp_bus_asserts.sv
// Checker on the parallel bus between host end and device end
`timescale 1ns/1ps

module duhp_bus_asserts (
    input logic       ref_clk_in,
    input logic       rstn_in,
    input logic [2:0] reg_sel_in,
    input logic [7:0] host_data_in,
    input logic       host_oe_in,
    input logic       dev_oe_in,
    input logic       rd_n_in,
    input logic       wr_n_in,
    input logic       sel_a_n_in,
    input logic       sel_b_n_in
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);

    a_strobes_exclusive: assert property (
        rd_n_in || wr_n_in)
        else $error("both strobes low");
    a_one_select: assert property (
        (!rd_n_in || !wr_n_in) |-> (sel_a_n_in ^ sel_b_n_in))
        else $error("strobe without exactly one select");
    a_idle_bus_free: assert property (
        (sel_a_n_in && sel_b_n_in && $past(sel_a_n_in && sel_b_n_in))
        |-> !dev_oe_in)
        else $error("bus driven while unselected");
    a_read_drives: assert property (
        ($fell(rd_n_in) && !(sel_a_n_in && sel_b_n_in)) |=> dev_oe_in)
        else $error("read not answered");
    a_read_holds: assert property (
        (!rd_n_in && !$past(rd_n_in)) |-> dev_oe_in)
        else $error("read data dropped early");
    a_read_release: assert property (
        $rose(rd_n_in) |=> !dev_oe_in)
        else $error("bus kept after read");
    a_write_owner: assert property (
        !wr_n_in |-> (host_oe_in && !dev_oe_in))
        else $error("wrong bus owner on write");
    a_read_length: assert property (
        $fell(rd_n_in) |-> !rd_n_in [*4] ##1 rd_n_in)
        else $error("read strobe length");
    a_write_length: assert property (
        $fell(wr_n_in) |-> !wr_n_in [*4] ##1 wr_n_in)
        else $error("write strobe length");
    a_addr_steady: assert property (
        ((!rd_n_in && !$past(rd_n_in)) || (!wr_n_in && !$past(wr_n_in)))
        |-> $stable(reg_sel_in))
        else $error("address moved in strobe");
    a_wdata_steady: assert property (
        (!wr_n_in && !$past(wr_n_in)) |-> $stable(host_data_in))
        else $error("write data moved in strobe");
endmodule : duhp_bus_asserts

// ===== verification/dual_uart_host_bus_port_tb.sv
// Self-checking bench: host end and device end joined by the bus
`timescale 1ns/1ps
`include "duhp_cfg.svh"

module dual_uart_host_bus_port_tb;
    localparam int BAUD = 64;
    logic       ref_clk_in;
    logic       rstn_in;
    logic       req_valid;
    logic       req_write;
    logic       req_chan;
    logic [2:0] req_addr;
    logic [7:0] req_data;
    logic       done;
    logic       busy;
    logic [7:0] rdata;
    wire  [1:0] ser;
    logic [1:0] irq;
    logic [1:0] irq_oe;
    logic [1:0] aux_n;
    logic [1:0] txr_n;
    logic [1:0] rxr_n;
    int         fail_count;
    int         n_compared;

    duhp_bus_if bus_if ();
    duhp_host duhp_host_inst (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
        .ce_in(1'b1), .bus(bus_if.host), .req_valid_in(req_valid),
        .req_write_in(req_write), .req_chan_in(req_chan),
        .req_addr_in(req_addr), .req_data_in(req_data), .busy_out(busy),
        .done_out(done), .rdata_out(rdata));
    duhp_device #(.BAUD_DIV(BAUD)) duhp_device_inst (.ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in), .ce_in(1'b1), .bus(bus_if.device),
        .serial_in_chan_in(ser), .serial_out_chan_out(ser),
        .irq_out_chan_out(irq), .irq_oe_chan_out(irq_oe),
        .aux_out_two_chan_n_out(aux_n), .xmit_ready_chan_n_out(txr_n),
        .recv_ready_chan_n_out(rxr_n));
    duhp_bus_asserts duhp_bus_asserts_inst (.ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in),
        .reg_sel_in(bus_if.register_select_lines),
        .host_data_in(bus_if.host_data), .host_oe_in(bus_if.host_data_oe),
        .dev_oe_in(bus_if.dev_data_oe),
        .rd_n_in(bus_if.read_strobe_n),
        .wr_n_in(bus_if.write_strobe_n),
        .sel_a_n_in(bus_if.chan_a_select_n),
        .sel_b_n_in(bus_if.chan_b_select_n));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic xfer(input logic w, input logic c, input logic [2:0] a,
                        input logic [7:0] d);
        int k;
        @(posedge ref_clk_in);
        req_valid <= 1'b1;
        req_write <= w;
        req_chan  <= c;
        req_addr  <= a;
        req_data  <= d;
        @(posedge ref_clk_in);
        req_valid <= 1'b0;
        @(negedge ref_clk_in);
        check({7'h00, busy}, 8'h01);
        for (k = 0; k < 20; k++) begin
            @(negedge ref_clk_in);
            if (done === 1'b1) break;
        end
        if (done !== 1'b1) begin
            fail_count++;
            $display("Error at %0t: transfer never completed", $time);
        end
    endtask : xfer

    // Waits for a pin to reach a level, bounded
    task automatic wait_pin(input int sel, input int ch, input logic lvl);
        int k;
        for (k = 0; k < 2000; k++) begin
            @(negedge ref_clk_in);
            if ((sel == 0 ? rxr_n[ch] : txr_n[ch]) === lvl) break;
        end
        if ((sel == 0 ? rxr_n[ch] : txr_n[ch]) !== lvl) begin
            fail_count++;
            $display("Error at %0t: pin never reached level", $time);
        end
    endtask : wait_pin

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    initial begin
        #300000;
        fail_count++;
        $display("Error at %0t: watchdog expired", $time);
        complete_run();
    end

    initial begin
        fail_count = 0;
        n_compared = 0;
        rstn_in    = 1'b0;
        req_valid  = 1'b0;
        req_write  = 1'b0;
        req_chan   = 1'b0;
        req_addr   = 3'h0;
        req_data   = 8'h00;
        repeat (3) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        @(negedge ref_clk_in);
        check({6'h00, ser}, 8'h03);
        check({6'h00, aux_n}, 8'h03);
        check({6'h00, irq_oe}, 8'h00);
        check({6'h00, txr_n}, 8'h00);
        check({6'h00, rxr_n}, 8'h03);
        $display("reset values done");
        xfer(1'b1, 1'b0, `DUHP_REG_SCR, 8'h5a);
        xfer(1'b1, 1'b1, `DUHP_REG_SCR, 8'ha5);
        xfer(1'b0, 1'b0, `DUHP_REG_SCR, 8'h00);
        check(rdata, 8'h5a);
        xfer(1'b0, 1'b1, `DUHP_REG_SCR, 8'h00);
        check(rdata, 8'ha5);
        xfer(1'b0, 1'b0, 3'h1, 8'h00);
        check(rdata, 8'h00);
        $display("register access done");
        xfer(1'b1, 1'b0, `DUHP_REG_MCTL, 8'h08);
        check({6'h00, irq_oe}, 8'h01);
        check({6'h00, aux_n}, 8'h02);
        xfer(1'b0, 1'b0, `DUHP_REG_MCTL, 8'h00);
        check(rdata, 8'h08);
        xfer(1'b1, 1'b0, `DUHP_REG_DATA, 8'h3c);
        wait_pin(0, 0, 1'b0);
        check({7'h00, rxr_n[0]}, 8'h00);
        check({7'h00, irq[0]}, 8'h01);
        xfer(1'b0, 1'b0, `DUHP_REG_DATA, 8'h00);
        check(rdata, 8'h3c);
        check({7'h00, rxr_n[0]}, 8'h01);
        xfer(1'b1, 1'b0, `DUHP_REG_MCTL, 8'h00);
        check({6'h00, irq_oe}, 8'h00);
        check({6'h00, aux_n}, 8'h03);
        $display("standard loop and out-two done");
        xfer(1'b1, 1'b1, `DUHP_REG_MCTL, 8'h40);
        // Line level follows the mode bit one cycle later
        @(negedge ref_clk_in);
        check({6'h00, ser}, 8'h01);
        xfer(1'b1, 1'b1, `DUHP_REG_DATA, 8'hc3);
        wait_pin(0, 1, 1'b0);
        xfer(1'b0, 1'b1, `DUHP_REG_DATA, 8'h00);
        check(rdata, 8'hc3);
        $display("infrared loop done");
        for (int i = 0; i < 132; i++) begin
            xfer(1'b1, 1'b0, `DUHP_REG_DATA, 8'(i));
        end
        check({6'h00, txr_n}, 8'h01);
        wait_pin(1, 0, 1'b0);
        check({7'h00, txr_n[0]}, 8'h00);
        // Two looped bytes held, transmitter still busy
        xfer(1'b0, 1'b0, `DUHP_REG_LSR, 8'h00);
        check(rdata, 8'h01);
        $display("transmit fifo fill done");
        complete_run();
    end
endmodule : dual_uart_host_bus_port_tb
